// [dma_ctl_regs.svh]
// register offsets, field positions and the control register reset value of the dma channel control block
`ifndef DMA_CTL_REGS_SVH
`define DMA_CTL_REGS_SVH
`define CTRL_OFF   8'h00
`define ADDR_OFF   8'h04
`define CNT_OFF    8'h08
`define CH_STRIDE  8'h10
`define STATUS_OFF 8'h20
`define IRQEN_OFF  8'h24
`define IRQCLR_OFF 8'h28
`define EN_BIT     7
`define SIZE_BIT   6
`define DIR_BIT    5
`define RPT_BIT    4
`define IE_BIT     3
`define CTRL_RST   8'h00
`endif

// [dma_ctl_pkg.sv]
// types shared by the dma channel control block
package dma_ctl_pkg;
	typedef enum logic [1:0] {MODE_IO, MODE_REPEAT, MODE_IDLE} mode_e;
	typedef enum logic [2:0] {
		REG_NONE, REG_CTRL, REG_ADDR, REG_CNT, REG_STATUS, REG_IRQEN, REG_IRQCLR
	} reg_id_e;
	typedef logic [7:0]  ctrl_t;
	typedef logic [23:0] addr_t;
	typedef logic [15:0] count_t;
endpackage

// [dma_ctl.sv]
// dma channel pair control in short address mode, apb register slave
// How it works
// - control register clears to zero on reset and on standby entry.
// - enabled channel transfers whenever its selected source fires.
// - disabled channel ignores every request.
// - enable bit sets only after a read that saw it zero.
// - i/o and idle modes clear the enable bit when the count ends.
// - clearing the enable bit raises the end interrupt only with bit 3 set.
// - bit 6 picks byte or 16-bit word transfers.
// - bit 5 steps address up or down, by 1 for bytes, 2 for words.
// - idle mode leaves the memory address unchanged.
// - bits 4 and 3 decode i/o, repeat or idle mode.
// - channel a codes 0-3 timers, 4 serial tx, 5 serial rx, 11x none.
// - channel b codes 0 and 1 pick timer channels 0 and 1.
// - channel b codes 2 and 3 use request pin falling edge, low level.
// - a source used by an enabled channel raises no cpu interrupt.
// - i/o and idle count down by one and end at zero.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "dma_ctl_regs.svh"
module dma_ctl (
	// clock and reset
	input  wire logic                core_clk_i,
	input  wire logic                rst_n_i,
	// apb slave
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [7:0]          paddr_i,
	input  wire logic [31:0]         pwdata_i,
	output logic      [31:0]         prdata_o,
	output logic                     pready_o,
	output logic                     pslverr_o,
	// power
	input  wire logic                standby_i,
	// activation sources
	input  wire logic [3:0]          timer_match_i,
	input  wire logic                sci_tx_empty_i,
	input  wire logic                sci_rx_full_i,
	input  wire logic                ext_req_n_i,
	// source interrupts passed to the cpu
	output logic      [3:0]          timer_irq_o,
	output logic                     sci_tx_irq_o,
	output logic                     sci_rx_irq_o,
	// transfer issue, index 0 is channel a
	output logic      [1:0]          xfer_valid_o,
	output logic      [1:0]          xfer_word_o,
	output dma_ctl_pkg::addr_t       xfer_addr_o [2],
	// interrupts
	output logic      [1:0]          transfer_end_interrupt_o,
	output logic                     irq_o
);
	import dma_ctl_pkg::*;

	localparam int NCH = 2;

	ctrl_t      ctrl_q [NCH];
	addr_t      addr_q [NCH];
	count_t     cnt_q  [NCH];
	logic [1:0] armed_q;
	logic [1:0] status_q;
	logic [1:0] irq_en_q;
	logic [31:0] prdata_q;
	logic [1:0] xvalid_q;
	logic [1:0] xword_q;
	addr_t      xaddr_q [NCH];
	logic       ext_s1_q;
	logic       ext_s2_q;
	logic       ext_prev_q;
	logic [1:0] fire;
	logic [1:0] hw_end;
	logic [1:0] end_evt;
	logic [5:0] src_mask;

	function automatic reg_id_e reg_of(input logic [7:0] a);
		logic [7:0] base;
		base = (a < `STATUS_OFF) ? (a & ~`CH_STRIDE) : a;
		case (base)
			`CTRL_OFF:   reg_of = REG_CTRL;
			`ADDR_OFF:   reg_of = REG_ADDR;
			`CNT_OFF:    reg_of = REG_CNT;
			`STATUS_OFF: reg_of = REG_STATUS;
			`IRQEN_OFF:  reg_of = REG_IRQEN;
			`IRQCLR_OFF: reg_of = REG_IRQCLR;
			default:     reg_of = REG_NONE;
		endcase
	endfunction

	function automatic mode_e mode_of(input ctrl_t c);
		if (!c[`RPT_BIT]) begin
			mode_of = MODE_IO;
		end else if (c[`IE_BIT]) begin
			mode_of = MODE_IDLE;
		end else begin
			mode_of = MODE_REPEAT;
		end
	endfunction

	// internal source index 0-3 timers, 4 serial tx, 5 serial rx; 7 means none
	function automatic logic [2:0] src_of(input ctrl_t c, input int ch);
		if (ch == 0) begin
			src_of = (c[2:1] == 2'h3) ? 3'h7 : c[2:0];
		end else begin
			src_of = c[1] ? 3'h7 : {2'h0, c[0]};
		end
	endfunction

	// apb: no wait states, read data is captured in the setup cycle
	logic    acc;
	logic    wr;
	logic    rd;
	reg_id_e acc_reg;
	logic    acc_ch;
	assign acc      = psel_i & penable_i;
	assign wr       = acc & pwrite_i;
	assign rd       = acc & ~pwrite_i;
	assign acc_reg  = reg_of(paddr_i);
	assign acc_ch   = paddr_i[4];
	assign pready_o = 1'b1;
	assign pslverr_o = acc & (acc_reg == REG_NONE);
	assign prdata_o = prdata_q;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_q <= 32'h0;
		end else if (psel_i & ~penable_i & ~pwrite_i) begin
			case (acc_reg)
				REG_CTRL:   prdata_q <= {24'h0, ctrl_q[acc_ch]};
				REG_ADDR:   prdata_q <= {8'h0, addr_q[acc_ch]};
				REG_CNT:    prdata_q <= {16'h0, cnt_q[acc_ch]};
				REG_STATUS: prdata_q <= {30'h0, status_q};
				REG_IRQEN:  prdata_q <= {30'h0, irq_en_q};
				default:    prdata_q <= 32'h0;
			endcase
		end
	end

	// request pin is asynchronous, so it is synchronised before the edge detector
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_s1_q   <= 1'b1;
			ext_s2_q   <= 1'b1;
			ext_prev_q <= 1'b1;
		end else begin
			ext_s1_q   <= ext_req_n_i;
			ext_s2_q   <= ext_s1_q;
			ext_prev_q <= ext_s2_q;
		end
	end

	genvar c;
	for (c = 0; c < NCH; c++) begin : g_ch
		logic   hit;
		logic   sel;
		mode_e  mode;
		addr_t  step;
		logic [7:0] hi_dec;

		assign sel  = wr & (acc_ch == 1'(c));
		assign mode = mode_of(ctrl_q[c]);
		assign step = ctrl_q[c][`SIZE_BIT] ? 24'h2 : 24'h1;
		assign hi_dec = cnt_q[c][15:8] - 8'h1;

		always_comb begin
			hit = 1'b0;
			if (c == 0) begin
				case (ctrl_q[c][2:0])
					3'h0, 3'h1, 3'h2, 3'h3: hit = timer_match_i[ctrl_q[c][1:0]];
					3'h4:    hit = sci_tx_empty_i;
					3'h5:    hit = sci_rx_full_i;
					default: hit = 1'b0;
				endcase
			end else begin
				case (ctrl_q[c][1:0])
					2'h0: hit = timer_match_i[0];
					2'h1: hit = timer_match_i[1];
					2'h2: hit = ext_prev_q & ~ext_s2_q;
					2'h3: hit = ~ext_s2_q;
				endcase
			end
		end

		assign fire[c]    = ctrl_q[c][`EN_BIT] & hit;
		assign hw_end[c]  = fire[c] & (mode != MODE_REPEAT) & (cnt_q[c] == 16'h1);
		assign end_evt[c] = hw_end[c] & ctrl_q[c][`IE_BIT];

		always_ff @(posedge core_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				ctrl_q[c] <= `CTRL_RST;
			end else if (standby_i) begin
				ctrl_q[c] <= `CTRL_RST;
			end else begin
				if (sel & (acc_reg == REG_CTRL)) begin
					// a one only lands if already set or armed by a read
					ctrl_q[c] <= {pwdata_i[7] & (ctrl_q[c][7] | armed_q[c]),
						pwdata_i[6:0]};
				end
				if (hw_end[c]) begin
					ctrl_q[c][`EN_BIT] <= 1'b0;
				end
			end
		end

		always_ff @(posedge core_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				armed_q[c] <= 1'b0;
			end else if (standby_i | (sel & (acc_reg == REG_CTRL))) begin
				armed_q[c] <= 1'b0;
			end else if (rd & (acc_ch == 1'(c)) & (acc_reg == REG_CTRL)
					& ~ctrl_q[c][`EN_BIT]) begin
				armed_q[c] <= 1'b1;
			end
		end

		// the transfer update wins over a software write in the same cycle
		always_ff @(posedge core_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				addr_q[c] <= 24'h0;
			end else if (fire[c]) begin
				if (mode != MODE_IDLE) begin
					addr_q[c] <= ctrl_q[c][`DIR_BIT] ? addr_q[c] - step
						: addr_q[c] + step;
				end
			end else if (sel & (acc_reg == REG_ADDR)) begin
				addr_q[c] <= pwdata_i[23:0];
			end
		end

		always_ff @(posedge core_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				cnt_q[c] <= 16'h0;
			end else if (fire[c]) begin
				if (mode != MODE_REPEAT) begin
					cnt_q[c] <= cnt_q[c] - 16'h1;
				end else if (hi_dec == 8'h0) begin
					cnt_q[c][15:8] <= cnt_q[c][7:0];
				end else begin
					cnt_q[c][15:8] <= hi_dec;
				end
			end else if (sel & (acc_reg == REG_CNT)) begin
				cnt_q[c] <= pwdata_i[15:0];
			end
		end

		always_ff @(posedge core_clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				xvalid_q[c] <= 1'b0;
				xword_q[c]  <= 1'b0;
				xaddr_q[c]  <= 24'h0;
			end else begin
				xvalid_q[c] <= fire[c];
				if (fire[c]) begin
					xword_q[c] <= ctrl_q[c][`SIZE_BIT];
					xaddr_q[c] <= addr_q[c];
				end
			end
		end

		assign xfer_addr_o[c] = xaddr_q[c];

		fire_en_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
			xfer_valid_o[c] |-> $past(ctrl_q[c][`EN_BIT]))
			else $error("transfer issued while disabled");
		off_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
			!ctrl_q[c][`EN_BIT] |=> !xfer_valid_o[c])
			else $error("disabled channel transferred");
		arm_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
			sel && acc_reg == REG_CTRL && pwdata_i[7] && !ctrl_q[c][7] && !armed_q[c]
			|=> !ctrl_q[c][`EN_BIT])
			else $error("enable set without prior read");
		end_clr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
			hw_end[c] |=> !ctrl_q[c][`EN_BIT])
			else $error("enable not cleared at end");
		end_irq_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
			$rose(status_q[c]) |-> $past(ctrl_q[c][`IE_BIT]) && $past(hw_end[c]))
			else $error("end interrupt without enable");
		word_size_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
			xfer_valid_o[c] |-> xfer_word_o[c] == $past(ctrl_q[c][`SIZE_BIT]))
			else $error("transfer size wrong");
		addr_step_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
			fire[c] && mode != MODE_IDLE && !ctrl_q[c][`DIR_BIT] |=>
			24'(addr_q[c] - $past(addr_q[c])) == ($past(ctrl_q[c][6]) ? 24'h2 : 24'h1))
			else $error("address step wrong");
		idle_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
			fire[c] && mode == MODE_IDLE |=> $stable(addr_q[c]))
			else $error("idle mode moved address");
		count_dec_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
			fire[c] && mode != MODE_REPEAT |=> cnt_q[c] == 16'($past(cnt_q[c]) - 16'h1))
			else $error("count did not decrement");
		hw_wins_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
			hw_end[c] && sel && acc_reg == REG_CTRL |=> !ctrl_q[c][`EN_BIT])
			else $error("software write beat hardware clear");
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_en_q <= 2'h0;
		end else if (wr & (acc_reg == REG_IRQEN)) begin
			irq_en_q <= pwdata_i[1:0];
		end
	end

	// a new end event wins over a clear in the same cycle
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status_q <= 2'h0;
		end else begin
			status_q <= (status_q & ~((wr & (acc_reg == REG_IRQCLR)) ? pwdata_i[1:0] : 2'h0))
				| end_evt;
		end
	end

	always_comb begin
		src_mask = 6'h0;
		for (int k = 0; k < NCH; k++) begin
			if (ctrl_q[k][`EN_BIT] && src_of(ctrl_q[k], k) != 3'h7) begin
				src_mask[src_of(ctrl_q[k], k)] = 1'b1;
			end
		end
	end

	assign timer_irq_o  = timer_match_i & ~src_mask[3:0];
	assign sci_tx_irq_o = sci_tx_empty_i & ~src_mask[4];
	assign sci_rx_irq_o = sci_rx_full_i & ~src_mask[5];
	assign xfer_valid_o = xvalid_q;
	assign xfer_word_o  = xword_q;
	assign transfer_end_interrupt_o = status_q;
	assign irq_o = |(status_q & irq_en_q);

	ctrl_rst_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		standby_i |=> ctrl_q[0] == 8'h0 && ctrl_q[1] == 8'h0)
		else $error("standby did not clear control");
	mode_dec_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		ctrl_q[0][4:3] == 2'h3 |-> g_ch[0].mode == MODE_IDLE)
		else $error("idle mode not decoded");
	sci_src_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		ctrl_q[0][7] && ctrl_q[0][2:0] == 3'h4 && sci_tx_empty_i |=> xfer_valid_o[0])
		else $error("serial tx source missed");
	tmr1_src_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		ctrl_q[1][7] && ctrl_q[1][1:0] == 2'h1 && timer_match_i[1] |=> xfer_valid_o[1])
		else $error("timer 1 source missed");
	ext_low_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		ctrl_q[1][7] && ctrl_q[1][1:0] == 2'h3 && !ext_s2_q |=> xfer_valid_o[1])
		else $error("low request level missed");
	src_mask_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		ctrl_q[0][7] && ctrl_q[0][2:0] == 3'h4 |-> !sci_tx_irq_o)
		else $error("claimed source reached cpu");
endmodule

// [dma_src_model.sv]
// far-side event sources: timer matches, serial events and the external request pin
`timescale 1ns/1ps
module dma_src_model (
	// clock
	input  wire logic clk_i,
	// events
	output logic [3:0] timer_match_o,
	output logic       sci_tx_empty_o,
	output logic       sci_rx_full_o,
	output logic       ext_req_n_o
);
	initial begin
		timer_match_o = 4'h0;
		sci_tx_empty_o = 1'b0;
		sci_rx_full_o = 1'b0;
		ext_req_n_o = 1'b1; // pin idles high, a request pulls it low
	end
	task automatic set_src(input int idx, input logic v);
		case (idx)
			0, 1, 2, 3: timer_match_o[idx] <= v;
			4: sci_tx_empty_o <= v;
			5: sci_rx_full_o <= v;
			default: ext_req_n_o <= ~v;
		endcase
	endtask
	// one event lasting n cycles, changed only just after rising edges
	task automatic pulse(input int idx, input int n);
		@(posedge clk_i);
		set_src(idx, 1'b1);
		repeat (n) @(posedge clk_i);
		set_src(idx, 1'b0);
	endtask
endmodule

// [tb.sv]
// self-checking bench for the dma channel control block
`timescale 1ns/1ps
`include "dma_ctl_regs.svh"
module tb;
	import dma_ctl_pkg::*;
	logic        clk, rst_n, psel, pen, pwr, stby, prdy, perr, ev, sti, sri, irq;
	logic [5:0]  claim;
	logic        stx, srx, ereq_n;
	logic [7:0]  pa, base, ctl;
	logic [31:0] pwd, prd, rv;
	logic [3:0]  tm, tirq;
	logic [1:0]  xv, xw, tend_o, last_w;
	addr_t       xa [2];
	addr_t       last_a [2];
	addr_t       a;
	int          fails, n_tests, nval [2], n0, c, code, s, bad14;
	logic [31:0] t_ctl [4] = '{32'h88, 32'h98, 32'h80, 32'h90};
	logic [31:0] t_cnt [4] = '{32'h1, 32'h1, 32'h1, 32'h0101};
	logic [31:0] t_end [4] = '{32'h08, 32'h18, 32'h00, 32'h90};
	logic [31:0] t_st [4] = '{32'h1, 32'h2, 32'h0, 32'h0};

	dma_ctl u_dma_ctl (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
		.pslverr_o(perr), .standby_i(stby), .timer_match_i(tm), .sci_tx_empty_i(stx),
		.sci_rx_full_i(srx), .ext_req_n_i(ereq_n), .timer_irq_o(tirq), .sci_tx_irq_o(sti),
		.sci_rx_irq_o(sri), .xfer_valid_o(xv), .xfer_word_o(xw), .xfer_addr_o(xa),
		.transfer_end_interrupt_o(tend_o), .irq_o(irq));
	dma_src_model u_src (.clk_i(clk), .timer_match_o(tm), .sci_tx_empty_o(stx),
		.sci_rx_full_o(srx), .ext_req_n_o(ereq_n));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// transfer monitor and source interrupt masking watch
	always @(posedge clk) begin
		for (int k = 0; k < 2; k++) if (xv[k] === 1'b1) begin
			nval[k]++;
			last_a[k] = xa[k];
			last_w[k] = xw[k];
		end
		// a source claimed by an enabled channel must not reach the cpu, others pass
		if (rst_n === 1'b1 && {srx, stx, tm} !== 6'h0
			&& {sri, sti, tirq} !== ({srx, stx, tm} & ~claim)) bad14++;
	end
	function automatic addr_t nxt(addr_t aa, logic [7:0] cv);
		if (cv[4] && cv[3]) return aa;
		return cv[5] ? aa - (cv[6] ? 24'h2 : 24'h1) : aa + (cv[6] ? 24'h2 : 24'h1);
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one apb transfer; waits for pready, outputs settle before return
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		pa <= ad;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		rv = prd;
		ev = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		#1;
	endtask
	// the enable bit only takes after a read that saw it clear
	task automatic arm_wr(input logic [7:0] b, input logic [31:0] v);
		bus(1'b0, b, 32'h0);
		bus(1'b1, b, v);
	endtask
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#(25 * 20000);
		fails++;
		complete_run();
	end

	initial begin
		{psel, pen, pwr, stby} = 4'h0;
		claim = 6'h0;
		pa = 8'h00;
		pwd = 32'h0;
		rst_n = 1'b0;
		void'($urandom(32'h39614743));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b1, 8'h00, 32'h80);
		bus(1'b0, 8'h00, 32'h0);
		chk("ctrl_a_reset", rv, 32'h0);
		bus(1'b0, 8'h10, 32'h0);
		chk("ctrl_b_reset", rv, 32'h0);
		// every select code of both channels, random size, direction and address
		for (int i = 0; i < 12; i++) begin
			c = (i > 7);
			code = c ? i - 8 : i;
			s = c ? (code > 1 ? 6 : code) : (code > 5 ? 0 : code);
			a = addr_t'($urandom);
			ctl = {1'b1, 1'($urandom), 1'($urandom), 2'b00, 3'(code)};
			base = 8'(c * 16);
			bus(1'b1, base + 8'h04, 32'(a));
			bus(1'b1, base + 8'h08, 32'h3);
			bus(1'b1, base, 32'(ctl & 8'h7f));
			n0 = nval[c];
			claim = 6'h0;
			u_src.pulse(s, 1);
			settle();
			chk("disabled_xfer", nval[c] - n0, 0);
			arm_wr(base, 32'(ctl));
			claim = ((c || code < 6) && s < 6) ? 6'(1 << s) : 6'h0;
			u_src.pulse(s, 1);
			settle();
			chk("xfer_count", nval[c] - n0, (c || code < 6));
			if (c || code < 6) begin
				chk("xfer_addr", last_a[c], a);
				chk("xfer_word", last_w[c], ctl[6]);
				bus(1'b0, base + 8'h04, 32'h0);
				chk("addr_step", rv, nxt(a, ctl));
			end
			bus(1'b1, base, 32'h0);
		end
		// end of count in each mode, end interrupt raised, masked and cleared
		bus(1'b1, 8'h24, 32'h3);
		claim = 6'h1;
		for (int j = 0; j < 4; j++) begin
			base = (j == 1) ? 8'h10 : 8'h00;
			a = addr_t'($urandom);
			bus(1'b1, base + 8'h04, 32'(a));
			bus(1'b1, base + 8'h08, t_cnt[j]);
			arm_wr(base, t_ctl[j]);
			u_src.pulse(0, 1);
			settle();
			bus(1'b0, base, 32'h0);
			chk("ctrl_after_end", rv, t_end[j]);
			bus(1'b0, base + 8'h04, 32'h0);
			chk("addr_after_end", rv, nxt(a, t_ctl[j][7:0]));
			bus(1'b0, 8'h20, 32'h0);
			chk("end_status", rv, t_st[j]);
			chk("end_flags", tend_o, t_st[j][1:0]);
			chk("irq_level", irq, t_st[j] != 0);
			if (j == 0) begin
				bus(1'b1, 8'h24, 32'h0);
				chk("irq_masked", irq, 1'b0);
				bus(1'b1, 8'h24, 32'h3);
			end
			bus(1'b1, 8'h28, 32'h3);
			chk("irq_cleared", irq, 1'b0);
			bus(1'b1, base, 32'h0);
		end
		// a hardware end in the same cycle as a control write keeps the enable clear
		bus(1'b1, 8'h08, 32'h1);
		arm_wr(8'h00, 32'h80);
		bus(1'b0, 8'h00, 32'h0);
		chk("enable_armed", rv, 32'h80);
		fork
			bus(1'b1, 8'h00, 32'hc0);
			begin
				@(posedge clk);
				u_src.pulse(0, 1);
			end
		join
		bus(1'b0, 8'h00, 32'h0);
		chk("hw_clear_wins", rv, 32'h40);
		claim = 6'h0;
		// standby entry clears an enabled channel
		arm_wr(8'h00, 32'h80);
		@(posedge clk);
		stby <= 1'b1;
		@(posedge clk);
		stby <= 1'b0;
		bus(1'b0, 8'h00, 32'h0);
		chk("ctrl_standby", rv, 32'h0);
		// a reset in mid-run clears an enabled channel as well
		arm_wr(8'h10, 32'h80);
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, 8'h10, 32'h0);
		chk("ctrl_b_rerun", rv, 32'h0);
		bus(1'b0, 8'h30, 32'h0);
		chk("unmapped_err", ev, 1'b1);
		chk("unmapped_data", rv, 32'h0);
		chk("src_irq_mask", bad14, 0);
		complete_run();
	end
endmodule
